// >>> logic/ldma_pkg.sv
`default_nettype none
package ldma_pkg;
    // apb byte offsets
    localparam logic [7:0] LDMA_OFF_CMD       = 8'h00;
    localparam logic [7:0] LDMA_OFF_DATA      = 8'h04;
    localparam logic [7:0] LDMA_OFF_ADDR_PTR  = 8'h08;
    localparam logic [7:0] LDMA_OFF_TEXT_CFG  = 8'h0c;
    localparam logic [7:0] LDMA_OFF_GFX_CFG   = 8'h10;
    localparam logic [7:0] LDMA_OFF_MODE      = 8'h14;
    localparam logic [7:0] LDMA_OFF_LINE      = 8'h18;
    localparam logic [7:0] LDMA_OFF_LINE_ADDR = 8'h1c;
    localparam logic [7:0] LDMA_OFF_LINE_END  = 8'h20;
    localparam logic [7:0] LDMA_OFF_CHAR      = 8'h24;
    localparam logic [7:0] LDMA_OFF_RENDER    = 8'h28;

    // command codes
    localparam logic [7:0] LDMA_CMD_OFFSET    = 8'h22;
    localparam logic [7:0] LDMA_CMD_ADDR_PTR  = 8'h24;
    localparam logic [7:0] LDMA_CMD_TEXT_BASE = 8'h40;
    localparam logic [7:0] LDMA_CMD_TEXT_PIT  = 8'h41;
    localparam logic [7:0] LDMA_CMD_GFX_BASE  = 8'h42;
    localparam logic [7:0] LDMA_CMD_GFX_PIT   = 8'h43;
    localparam logic [3:0] LDMA_CMD_MODE_HI   = 4'h8;

    // mode-set low three bits
    localparam logic [2:0] LDMA_MODE_OR   = 3'h0;
    localparam logic [2:0] LDMA_MODE_XOR  = 3'h1;
    localparam logic [2:0] LDMA_MODE_AND  = 3'h3;
    localparam logic [2:0] LDMA_MODE_ATTR = 3'h4;
    localparam int         LDMA_MODE_EXT_BIT = 3;

    // attribute codes in d2..d0
    localparam logic [2:0] LDMA_ATTR_NORMAL  = 3'h0;
    localparam logic [2:0] LDMA_ATTR_REVERSE = 3'h5;
    localparam logic [2:0] LDMA_ATTR_INHIBIT = 3'h3;
    localparam logic [2:0] LDMA_ATTR_BOLD    = 3'h7;
    localparam int         LDMA_ATTR_BLINK_BIT = 3;

    // character generator address layout
    localparam int LDMA_CG_OFF_LSB  = 11;
    localparam int LDMA_CG_CODE_LSB = 3;
    localparam logic [7:0] LDMA_ROM_LAST_CODE = 8'h7f;

    // reset values
    localparam logic [15:0] LDMA_RST_BASE   = 16'h0000;
    localparam logic [7:0]  LDMA_RST_PITCH  = 8'h00;
    localparam logic [4:0]  LDMA_RST_OFFSET = 5'h00;
    localparam logic [7:0]  LDMA_RST_LINE   = 8'h01;

    typedef enum logic [1:0] {
        LDMA_COMB_OR  = 2'h0,
        LDMA_COMB_XOR = 2'h1,
        LDMA_COMB_AND = 2'h2
    } ldma_comb_e;
endpackage : ldma_pkg
`default_nettype wire

// >>> logic/ldma_core.sv
`timescale 1ns/1ps
`default_nettype none
module ldma_core
    import ldma_pkg::*;
#(
    parameter logic [7:0] COLS_LL = 8'h28,
    parameter logic [7:0] COLS_LH = 8'h40,
    parameter logic [7:0] COLS_HL = 8'h50,
    parameter logic [7:0] COLS_HH = 8'h20
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        column_sel_lo_pin,
    input  wire logic        column_sel_hi_pin,
    output logic      [15:0] ram_addr,
    output logic      [15:0] cg_addr,
    output logic             cg_use_ext,
    output logic      [1:0]  combine_mode,
    output logic             attr_mode,
    output logic             gfx_render_en,
    output logic             attr_reverse,
    output logic             attr_inhibit,
    output logic             attr_bold,
    output logic             attr_blink
);
    logic [1:0]  col_meta_r, col_sync_r;
    logic [15:0] text_base_r, text_base_nxt, graphic_base_r, graphic_base_nxt;
    logic [7:0]  text_pitch_r, text_pitch_nxt, graphic_pitch_r, graphic_pitch_nxt;
    logic [4:0]  offset_r, offset_nxt;
    logic [15:0] addr_ptr_r, addr_ptr_nxt;
    ldma_comb_e  comb_r, comb_nxt;
    logic        ext_cg_r, ext_cg_nxt, attr_r, attr_nxt;
    logic [7:0]  op1_r, op1_nxt, op2_r, op2_nxt, last_cmd_r, last_cmd_nxt;
    logic        op_cnt_r, op_cnt_nxt;
    logic [7:0]  line_r, line_nxt, char_r, char_nxt, attr_byte_r, attr_byte_nxt;
    logic [2:0]  row_r, row_nxt;
    logic [31:0] prdata_nxt;
    logic        pready_nxt, pslverr_nxt;
    logic [15:0] cg_addr_nxt;
    logic        use_ext_nxt, rev_nxt, inh_nxt, bold_nxt, blink_nxt, unspec_nxt, unspec_r;
    logic [7:0]  visible_columns;
    logic [7:0]  line_idx;
    logic [15:0] text_start, text_end, gfx_start, gfx_end;
    logic        wr_acc, setup;
    logic [7:0]  cmd_byte;
    logic        mapped, writable;

    // column-select pins pass two flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            col_meta_r <= 2'h0;
            col_sync_r <= 2'h0;
        end
        else
        begin
            col_meta_r <= {column_sel_hi_pin, column_sel_lo_pin};
            col_sync_r <= col_meta_r;
        end
    end

    always_comb
    begin
        unique case (col_sync_r)
            2'h0:    visible_columns = COLS_LL;
            2'h1:    visible_columns = COLS_LH;
            2'h2:    visible_columns = COLS_HL;
            default: visible_columns = COLS_HH;
        endcase
    end

    // line addresses, line numbers start at one
    always_comb
    begin
        line_idx   = line_r - 8'h01;
        text_start = 16'(text_base_r + 16'(line_idx * text_pitch_r));
        text_end   = 16'(text_start + {8'h00, visible_columns});
        gfx_start  = 16'(graphic_base_r + 16'(line_idx * graphic_pitch_r));
        gfx_end    = 16'(gfx_start + {8'h00, visible_columns});
    end

    always_comb
    begin
        setup    = psel && !penable;
        wr_acc   = psel && penable && pready && pwrite;
        cmd_byte = pwdata[7:0];
        mapped   = 1'b1;
        writable = 1'b0;
        prdata_nxt = 32'h0000_0000;
        unique case (paddr)
            LDMA_OFF_CMD:
            begin
                prdata_nxt = {24'h000000, last_cmd_r};
                writable   = 1'b1;
            end
            LDMA_OFF_DATA:
            begin
                prdata_nxt = {15'h0000, op_cnt_r, op2_r, op1_r};
                writable   = 1'b1;
            end
            LDMA_OFF_ADDR_PTR:  prdata_nxt = {16'h0000, addr_ptr_r};
            LDMA_OFF_TEXT_CFG:  prdata_nxt = {8'h00, text_pitch_r, text_base_r};
            LDMA_OFF_GFX_CFG:   prdata_nxt = {8'h00, graphic_pitch_r, graphic_base_r};
            LDMA_OFF_MODE:
                prdata_nxt = {8'h00, visible_columns, 7'h00, offset_r, attr_r, ext_cg_r, comb_r};
            LDMA_OFF_LINE:
            begin
                prdata_nxt = {24'h000000, line_r};
                writable   = 1'b1;
            end
            LDMA_OFF_LINE_ADDR: prdata_nxt = {gfx_start, text_start};
            LDMA_OFF_LINE_END:  prdata_nxt = {gfx_end, text_end};
            LDMA_OFF_CHAR:
            begin
                prdata_nxt = {8'h00, attr_byte_r, 5'h00, row_r, char_r};
                writable   = 1'b1;
            end
            LDMA_OFF_RENDER:
                prdata_nxt = {10'h000, unspec_r, attr_blink, attr_bold, attr_inhibit, attr_reverse,
                              cg_use_ext, cg_addr};
            default:
                mapped = 1'b0;
        endcase
        pready_nxt  = setup;
        pslverr_nxt = setup && (!mapped || (pwrite && !writable));
        if (!setup || pwrite)
            prdata_nxt = 32'h0000_0000;

        text_base_nxt     = text_base_r;
        text_pitch_nxt    = text_pitch_r;
        graphic_base_nxt  = graphic_base_r;
        graphic_pitch_nxt = graphic_pitch_r;
        offset_nxt        = offset_r;
        addr_ptr_nxt      = addr_ptr_r;
        comb_nxt          = comb_r;
        ext_cg_nxt        = ext_cg_r;
        attr_nxt          = attr_r;
        op1_nxt           = op1_r;
        op2_nxt           = op2_r;
        op_cnt_nxt        = op_cnt_r;
        last_cmd_nxt      = last_cmd_r;
        line_nxt          = line_r;
        char_nxt          = char_r;
        row_nxt           = row_r;
        attr_byte_nxt     = attr_byte_r;
        if (wr_acc && paddr == LDMA_OFF_DATA)
        begin
            // operands arrive before their command, first then second
            if (!op_cnt_r)
                op1_nxt = pwdata[7:0];
            else
                op2_nxt = pwdata[7:0];
            op_cnt_nxt = 1'b1;
        end
        if (wr_acc && paddr == LDMA_OFF_LINE)
            line_nxt = pwdata[7:0];
        if (wr_acc && paddr == LDMA_OFF_CHAR)
        begin
            char_nxt      = pwdata[7:0];
            row_nxt       = pwdata[10:8];
            attr_byte_nxt = pwdata[23:16];
        end
        if (wr_acc && paddr == LDMA_OFF_CMD)
        begin
            last_cmd_nxt = cmd_byte;
            op_cnt_nxt   = 1'b0;
            if (cmd_byte == LDMA_CMD_OFFSET)
                offset_nxt = op1_r[4:0];
            if (cmd_byte == LDMA_CMD_ADDR_PTR)
                addr_ptr_nxt = {op2_r, op1_r};
            if (cmd_byte == LDMA_CMD_TEXT_BASE)
                text_base_nxt = {op2_r, op1_r};
            if (cmd_byte == LDMA_CMD_GFX_BASE)
                graphic_base_nxt = {op2_r, op1_r};
            if (cmd_byte == LDMA_CMD_TEXT_PIT)
                text_pitch_nxt = op1_r;
            if (cmd_byte == LDMA_CMD_GFX_PIT)
                graphic_pitch_nxt = op1_r;
            if (cmd_byte[7:4] == LDMA_CMD_MODE_HI)
            begin
                ext_cg_nxt = cmd_byte[LDMA_MODE_EXT_BIT];
                if (cmd_byte[2:0] inside {LDMA_MODE_OR, LDMA_MODE_XOR, LDMA_MODE_AND})
                    attr_nxt = 1'b0;
                unique case (cmd_byte[2:0])
                    LDMA_MODE_OR:   comb_nxt = LDMA_COMB_OR;
                    LDMA_MODE_XOR:  comb_nxt = LDMA_COMB_XOR;
                    LDMA_MODE_AND:  comb_nxt = LDMA_COMB_AND;
                    LDMA_MODE_ATTR: attr_nxt = 1'b1;
                    default:        attr_nxt = attr_r;
                endcase
            end
        end

        // pattern fetch address and source
        cg_addr_nxt = {offset_r, char_r, row_r};
        use_ext_nxt = ext_cg_r || (char_r > LDMA_ROM_LAST_CODE);
        // attribute byte decode, upper nibble ignored
        rev_nxt    = 1'b0;
        inh_nxt    = 1'b0;
        bold_nxt   = 1'b0;
        unspec_nxt = 1'b0;
        unique case (attr_byte_r[2:0])
            LDMA_ATTR_NORMAL:  rev_nxt  = 1'b0;
            LDMA_ATTR_REVERSE: rev_nxt  = 1'b1;
            LDMA_ATTR_INHIBIT: inh_nxt  = 1'b1;
            LDMA_ATTR_BOLD:    bold_nxt = 1'b1;
            default:           unspec_nxt = 1'b1;
        endcase
        blink_nxt = attr_byte_r[LDMA_ATTR_BLINK_BIT];
        if (!attr_r)
        begin
            rev_nxt    = 1'b0;
            inh_nxt    = 1'b0;
            bold_nxt   = 1'b0;
            blink_nxt  = 1'b0;
            unspec_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            text_base_r     <= LDMA_RST_BASE;
            graphic_base_r  <= LDMA_RST_BASE;
            text_pitch_r    <= LDMA_RST_PITCH;
            graphic_pitch_r <= LDMA_RST_PITCH;
            offset_r        <= LDMA_RST_OFFSET;
            addr_ptr_r      <= LDMA_RST_BASE;
            comb_r          <= LDMA_COMB_OR;
            ext_cg_r        <= 1'b0;
            attr_r          <= 1'b0;
            op1_r           <= 8'h00;
            op2_r           <= 8'h00;
            op_cnt_r        <= 1'b0;
            last_cmd_r      <= 8'h00;
            line_r          <= LDMA_RST_LINE;
            char_r          <= 8'h00;
            row_r           <= 3'h0;
            attr_byte_r     <= 8'h00;
            prdata          <= 32'h0000_0000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            ram_addr        <= LDMA_RST_BASE;
            cg_addr         <= 16'h0000;
            cg_use_ext      <= 1'b0;
            combine_mode    <= 2'h0;
            attr_mode       <= 1'b0;
            gfx_render_en   <= 1'b1;
            attr_reverse    <= 1'b0;
            attr_inhibit    <= 1'b0;
            attr_bold       <= 1'b0;
            attr_blink      <= 1'b0;
            unspec_r        <= 1'b0;
        end
        else
        begin
            text_base_r     <= text_base_nxt;
            graphic_base_r  <= graphic_base_nxt;
            text_pitch_r    <= text_pitch_nxt;
            graphic_pitch_r <= graphic_pitch_nxt;
            offset_r        <= offset_nxt;
            addr_ptr_r      <= addr_ptr_nxt;
            comb_r          <= comb_nxt;
            ext_cg_r        <= ext_cg_nxt;
            attr_r          <= attr_nxt;
            op1_r           <= op1_nxt;
            op2_r           <= op2_nxt;
            op_cnt_r        <= op_cnt_nxt;
            last_cmd_r      <= last_cmd_nxt;
            line_r          <= line_nxt;
            char_r          <= char_nxt;
            row_r           <= row_nxt;
            attr_byte_r     <= attr_byte_nxt;
            prdata          <= prdata_nxt;
            pready          <= pready_nxt;
            pslverr         <= pslverr_nxt;
            ram_addr        <= addr_ptr_nxt;
            cg_addr         <= cg_addr_nxt;
            cg_use_ext      <= use_ext_nxt;
            combine_mode    <= comb_nxt;
            attr_mode       <= attr_nxt;
            gfx_render_en   <= !attr_nxt;
            attr_reverse    <= rev_nxt;
            attr_inhibit    <= inh_nxt;
            attr_bold       <= bold_nxt;
            attr_blink      <= blink_nxt;
            unspec_r        <= unspec_nxt;
        end
    end

    AST_CG_LAYOUT: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 cg_addr == {$past(offset_r), $past(char_r), $past(row_r)})
        else $error("pattern address does not follow offset, code and row");
    AST_ROM_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (!ext_cg_r && char_r <= 8'h7f) |=> !cg_use_ext)
        else $error("low code not taken from rom");
    AST_EXT_ALL: assert property (@(posedge pclk) disable iff (!presetn)
        ext_cg_r |=> cg_use_ext)
        else $error("external generator mode fetched from rom");
    AST_TEXT_BASE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == 8'h00 && pwdata[7:0] == 8'h40) |=> text_base_r == {$past(op2_r), $past(op1_r)})
        else $error("text base not loaded low then high");
    AST_PTR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == 8'h00 && pwdata[7:0] == 8'h24) |=> ram_addr == {$past(op2_r), $past(op1_r)})
        else $error("address pointer not loaded from operands");
    AST_CONTIG: assert property (@(posedge pclk) disable iff (!presetn)
        (graphic_pitch_r == visible_columns && line_r > 8'h01)
        |-> gfx_start == 16'(graphic_base_r + 16'((line_r - 8'h02) * graphic_pitch_r) + {8'h00, visible_columns}))
        else $error("graphic lines not contiguous");
    AST_MODE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_acc && paddr == 8'h00 && pwdata[7:4] == 4'h8)
        |=> $stable(combine_mode) && $stable(attr_mode) && $stable(ext_cg_r))
        else $error("mode changed without mode-set command");
    AST_UNDEF_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == 8'h00 && pwdata[7:4] == 4'h8 && pwdata[2:0] == 3'h2)
        |=> combine_mode == $past(combine_mode) && attr_mode == $past(attr_mode))
        else $error("undefined mode code altered combine mode");
    AST_ATTR_GFX: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == 8'h00 && pwdata[7:4] == 4'h8 && pwdata[2:0] == 3'h4) |=> attr_mode && !gfx_render_en)
        else $error("graphics rendered in attribute mode");
    AST_BOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (attr_r && attr_byte_r[2:0] == 3'h7) |=> attr_bold && !attr_reverse && !attr_inhibit)
        else $error("bold attribute decoded wrongly");
    AST_BLINK: assert property (@(posedge pclk) disable iff (!presetn)
        (attr_r && attr_byte_r[3]) |=> attr_blink)
        else $error("blink bit ignored");
endmodule : ldma_core
`default_nettype wire

// >>> sim/ldma_host.sv
`timescale 1ns/1ps
`default_nettype none
module ldma_host
    import ldma_pkg::*;
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer
    task automatic mode(input logic [7:0] code);
        logic [31:0] rd;
        logic        er;
        xfer(1'b1, LDMA_OFF_CMD, {24'h0, code}, rd, er);
    endtask : mode
    // two operands, first then second, then the command byte
    task automatic cmd(input logic [7:0] code, input logic [7:0] op1, input logic [7:0] op2);
        logic [31:0] rd;
        logic        er;
        xfer(1'b1, LDMA_OFF_DATA, {24'h0, op1}, rd, er);
        xfer(1'b1, LDMA_OFF_DATA, {24'h0, op2}, rd, er);
        xfer(1'b1, LDMA_OFF_CMD, {24'h0, code}, rd, er);
    endtask : cmd
    // sends command byte 9c, which the core does not decode
    task automatic display_on;
        mode(8'h9c);
    endtask : display_on
endmodule : ldma_host
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ldma_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lo_pin, hi_pin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] ram_addr, cg_addr;
    logic [1:0]  combine_mode;
    logic cg_use_ext, attr_mode, gfx_render_en, attr_reverse, attr_inhibit, attr_bold, attr_blink;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    ldma_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .column_sel_lo_pin(lo_pin), .column_sel_hi_pin(hi_pin), .ram_addr(ram_addr),
        .cg_addr(cg_addr), .cg_use_ext(cg_use_ext), .combine_mode(combine_mode),
        .attr_mode(attr_mode), .gfx_render_en(gfx_render_en), .attr_reverse(attr_reverse),
        .attr_inhibit(attr_inhibit), .attr_bold(attr_bold), .attr_blink(attr_blink));
    ldma_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    always #12.5 pclk = ~pclk;
    task automatic conclude;
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] rd;
        logic        er;
        host.xfer(1'b0, a, 32'h0, rd, er);
        chk(rd, exp, msg);
    endtask : rdchk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        host.xfer(1'b1, a, d, rd, er);
    endtask : wr
    task automatic settle;
        repeat (4) @(posedge pclk);
        #1;
    endtask : settle
    task automatic t_reset;
        rdchk(LDMA_OFF_TEXT_CFG, 32'h0, "text cfg reset");
        rdchk(LDMA_OFF_GFX_CFG, 32'h0, "gfx cfg reset");
        rdchk(LDMA_OFF_LINE, 32'h1, "line reset");
        rdchk(LDMA_OFF_MODE, 32'h0020_0000, "mode reset");
        chk({29'h0, gfx_render_en, combine_mode}, 32'h4, "render reset");
    endtask : t_reset
    task automatic t_lines;
        host.cmd(LDMA_CMD_TEXT_BASE, 8'h34, 8'h12);
        host.cmd(LDMA_CMD_TEXT_PIT, 8'h20, 8'h00);
        host.cmd(LDMA_CMD_GFX_BASE, 8'h00, 8'h02);
        host.cmd(LDMA_CMD_GFX_PIT, 8'h20, 8'h00);
        rdchk(LDMA_OFF_TEXT_CFG, 32'h0020_1234, "text cfg");
        rdchk(LDMA_OFF_GFX_CFG, 32'h0020_0200, "gfx cfg");
        wr(LDMA_OFF_LINE, 32'h3);
        rdchk(LDMA_OFF_LINE_ADDR, 32'h0240_1274, "line start");
        rdchk(LDMA_OFF_LINE_END, 32'h0260_1294, "line end");
        wr(LDMA_OFF_LINE, 32'h4);
        rdchk(LDMA_OFF_LINE_ADDR, 32'h0260_1294, "contiguous");
        @(posedge pclk);
        lo_pin <= 1'b0;
        hi_pin <= 1'b0;
        settle();
        rdchk(LDMA_OFF_LINE_END, 32'h0288_12bc, "40 columns");
        lo_pin <= 1'b1;
        hi_pin <= 1'b1;
        settle();
    endtask : t_lines
    task automatic t_mode;
        logic [7:0] code [7] = '{8'h81, 8'h83, 8'h24, 8'h82, 8'h8c, 8'h88, 8'h80};
        logic [3:0] exp  [7] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'he, 4'h8, 4'h0};
        foreach (code[i])
        begin
            host.mode(code[i]);
            settle();
            chk({28'h0, cg_use_ext, attr_mode, combine_mode}, {28'h0, exp[i]}, "mode");
            chk({31'h0, gfx_render_en}, {31'h0, ~exp[i][2]}, "gfx off");
        end
    endtask : t_mode
    task automatic t_ptr;
        logic [31:0] rd;
        logic        er;
        host.cmd(LDMA_CMD_ADDR_PTR, 8'h34, 8'h12);
        settle();
        chk({16'h0, ram_addr}, 32'h1234, "ptr port");
        rdchk(LDMA_OFF_DATA, 32'h0000_1234, "operands held");
        rdchk(LDMA_OFF_CMD, 32'h0000_0024, "last command");
        host.xfer(1'b1, LDMA_OFF_ADDR_PTR, 32'h5555, rd, er);
        chk({31'h0, er}, 32'h1, "read-only write err");
        rdchk(LDMA_OFF_ADDR_PTR, 32'h1234, "ptr reg");
        host.xfer(1'b0, 8'h3c, 32'h0, rd, er);
        chk(rd, 32'h0, "unmapped");
        chk({31'h0, er}, 32'h1, "unmapped err");
        #1;
        chk({30'h0, pready, pslverr}, 32'h0, "err released");
    endtask : t_ptr
    task automatic cg_case(input logic [7:0] off, input logic [7:0] md, input logic [31:0] chw,
                           input logic [16:0] exp);
        host.cmd(LDMA_CMD_OFFSET, off, 8'h00);
        host.mode(md);
        wr(LDMA_OFF_CHAR, chw);
        settle();
        chk({15'h0, cg_use_ext, cg_addr}, {15'h0, exp}, "cg port");
        rdchk(LDMA_OFF_RENDER, {15'h0, exp}, "cg reg");
    endtask : cg_case
    task automatic t_attr;
        logic [7:0] ab [7] = '{8'hf0, 8'h05, 8'h03, 8'h07, 8'h0d, 8'h0b, 8'h02};
        logic [4:0] e  [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h09, 5'h0a, 5'h10};
        host.display_on();
        host.mode(8'h84);
        foreach (ab[i])
        begin
            wr(LDMA_OFF_CHAR, {8'h00, ab[i], 16'h0041});
            settle();
            chk({28'h0, attr_blink, attr_bold, attr_inhibit, attr_reverse}, {28'h0, e[i][3:0]}, "attr");
            rdchk(LDMA_OFF_RENDER, {10'h0, e[i], 17'h0fa08}, "attr reg");
        end
    endtask : t_attr
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        lo_pin = 1'b1;
        hi_pin = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_lines();
        t_mode();
        t_ptr();
        cg_case(8'h02, 8'h80, 32'h0000_0580, 17'h1_1405);
        cg_case(8'h02, 8'h80, 32'h0000_007f, 17'h0_13f8);
        cg_case(8'h1f, 8'h80, 32'h0000_07ff, 17'h1_ffff);
        cg_case(8'h1f, 8'h88, 32'h0000_0000, 17'h1_f800);
        t_attr();
        conclude();
    end
endmodule : tb
`default_nettype wire
